//--- design/vfsr_pkg.sv
// Constants and types for the video flywheel with switch-line resync
// Overview of operation
// - Flywheel runs only in SMPTE mode; counters held idle otherwise.
// - Counters track total and active line length, total and active lines.
// - Raster learned from TRS H/V bits; synchronized only after one full frame.
// - Once synchronized, incoming TRS timing keeps being compared with the counters.
// - Hold select low: every TRS word reloads pixel counter; line counter reloads only at frame-start EAV.
// - Hold select high: reload only after two matching lines disagree with flywheel.
// - Flywheel disabled while lock or combined reset is low.
// - Rising lock or combined reset forces resync on next TRS word.
// - Hold select sampled each clock; rise within active line forces resync.
// - Detected standard triggers automatic resync at its switch line.
// - 525-line: end of lines 10 and 273 interlaced, line 10 progressive.
// - 625-line: end of lines 6 and 319 interlaced, line 6 progressive.
// - 750-line progressive: end of line 7.
// - 1125-line: end of lines 7 and 568 interlaced, line 7 progressive.
// - 1125-line: segmented flagged from payload id, or from 2750-word lines so 24-frame segmented is identified.
// - H, V, F come from TRS words when hold low, flywheel when high.
package vfsr_pkg;
  localparam int WORD_W = 10;
  localparam int PIX_W = 12;
  localparam int LINE_W = 11;
  localparam int BIT_F = 8;
  localparam int BIT_V = 7;
  localparam int BIT_H = 6;
  localparam logic [WORD_W-1:0] TRS_ONES = 10'h3ff;
  localparam logic [WORD_W-1:0] TRS_ZERO = 10'h000;
  localparam logic [PIX_W-1:0] PIX_ONE = 12'h001;
  localparam logic [PIX_W-1:0] ACT_ADJ = 12'h004;
  localparam logic [PIX_W-1:0] PIX_1125_24 = 12'habe;
  localparam logic [LINE_W-1:0] LINE_ONE = 11'h001;
  localparam logic [LINE_W-1:0] LINES_525 = 11'h20d;
  localparam logic [LINE_W-1:0] LINES_625 = 11'h271;
  localparam logic [LINE_W-1:0] LINES_750 = 11'h2ee;
  localparam logic [LINE_W-1:0] LINES_1125 = 11'h465;
  localparam logic [LINE_W-1:0] SW_525_A = 11'h00a;
  localparam logic [LINE_W-1:0] SW_525_B = 11'h111;
  localparam logic [LINE_W-1:0] SW_625_A = 11'h006;
  localparam logic [LINE_W-1:0] SW_625_B = 11'h13f;
  localparam logic [LINE_W-1:0] SW_750_A = 11'h007;
  localparam logic [LINE_W-1:0] SW_1125_A = 11'h007;
  localparam logic [LINE_W-1:0] SW_1125_B = 11'h238;
  localparam logic [1:0] FV_MARK = 2'h1;
  localparam logic [2:0] STD_NONE = 3'h0;
  localparam logic [2:0] STD_525 = 3'h1;
  localparam logic [2:0] STD_625 = 3'h2;
  localparam logic [2:0] STD_750 = 3'h3;
  localparam logic [2:0] STD_1125 = 3'h4;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_LEARN = 3'h2,
    ST_SYNC = 3'h4
  } vfsr_state_t;
endpackage : vfsr_pkg

//--- design/vfsr_sync3.sv
// Three-stage pin synchronizer with agreement filter
`timescale 1ns/1ps
module vfsr_sync3 (
  input wire logic clk, // Pixel clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic pin, // Asynchronous pin level
  output logic level // Filtered level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  wire agree = (s2_reg == s3_reg);
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level <= 1'b0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (agree) begin
        level <= s3_reg;
      end
    end
  end
endmodule : vfsr_sync3

//--- design/vfsr_flywheel.sv
// Video timing flywheel with noise-immune and switch-line resynchronization
`timescale 1ns/1ps
module vfsr_flywheel (
  input wire logic clk, // Pixel clock, 10 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [vfsr_pkg::WORD_W-1:0] din, // Aligned descrambled word
  input wire logic smpte_mode, // Receiver in SMPTE mode
  input wire logic locked, // Lock indication
  input wire logic combined_reset_n_pin, // Combined reset pin, active low
  input wire logic flywheel_hold_select, // Flywheel control pin
  input wire logic pid_segmented, // Payload id says segmented frame
  output logic timing_valid, // Full frame learned
  output logic h_out, // Horizontal blanking
  output logic v_out, // Vertical blanking
  output logic f_out, // Field
  output logic reload_pulse, // Counters reloaded at EAV
  output logic [vfsr_pkg::PIX_W-1:0] total_pix, // Words per line
  output logic [vfsr_pkg::PIX_W-1:0] active_pix, // Active words per line
  output logic [vfsr_pkg::LINE_W-1:0] total_lines, // Lines per frame
  output logic [vfsr_pkg::LINE_W-1:0] active_lines, // Active lines per frame
  output logic [2:0] std_format, // Detected line standard
  output logic std_interlaced, // Interlaced raster
  output logic std_segmented // Segmented-frame raster
);
  import vfsr_pkg::*;

  function automatic logic [2:0] std_code(input logic [LINE_W-1:0] lines);
    case (lines)
      LINES_525: std_code = STD_525;
      LINES_625: std_code = STD_625;
      LINES_750: std_code = STD_750;
      LINES_1125: std_code = STD_1125;
      default: std_code = STD_NONE;
    endcase
  endfunction : std_code

  function automatic logic is_switch(input logic [LINE_W-1:0] ln, input logic [2:0] code,
                                     input logic il);
    case (code)
      STD_525: is_switch = (ln == SW_525_A) || (il && ln == SW_525_B);
      STD_625: is_switch = (ln == SW_625_A) || (il && ln == SW_625_B);
      STD_750: is_switch = (ln == SW_750_A);
      STD_1125: is_switch = (ln == SW_1125_A) || (il && ln == SW_1125_B);
      default: is_switch = 1'b0;
    endcase
  endfunction : is_switch

  logic hold_s;
  logic rstpin_s;
  vfsr_sync3 u_hold_sync (.clk(clk), .rst(rst), .pin(flywheel_hold_select), .level(hold_s));
  vfsr_sync3 u_rst_sync (.clk(clk), .rst(rst), .pin(combined_reset_n_pin), .level(rstpin_s));

  logic [WORD_W-1:0] w1_reg, w2_reg, w3_reg;
  logic hold_d_reg, rstpin_d_reg, locked_d_reg;
  vfsr_state_t state_reg, state_next;
  logic [PIX_W-1:0] pix_reg, pix_next, sav_reg;
  logic [LINE_W-1:0] line_reg, line_next, act_cnt_reg;
  logic armed_reg, ilace_reg, resync_reg, resync_next;
  logic err_valid_reg, err_valid_next;
  logic [PIX_W-1:0] err_pos_reg;
  logic [1:0] prev_fv_reg;
  logic [2:0] rx_hvf_reg;
  logic [1:0] vf_mem [0:(1<<LINE_W)-1];

  wire trs = (w3_reg == TRS_ONES) && (w2_reg == TRS_ZERO) && (w1_reg == TRS_ZERO);
  wire rx_eav = trs && din[BIT_H];
  wire rx_sav = trs && !din[BIT_H];
  wire [1:0] rx_fv = {din[BIT_F], din[BIT_V]};
  wire enable = smpte_mode && locked && rstpin_s;
  wire lock_rise = locked && !locked_d_reg;
  wire rst_rise = rstpin_s && !rstpin_d_reg;
  wire hold_rise = hold_s && !hold_d_reg;
  wire synced = (state_reg == ST_SYNC);
  wire learning = (state_reg == ST_LEARN);
  wire fw_eol = synced && (pix_reg == total_pix - PIX_ONE);
  wire line_wrap = synced && (line_reg >= total_lines);
  wire [LINE_W-1:0] line_inc = line_wrap ? LINE_ONE : line_reg + LINE_ONE;
  wire [1:0] fw_fv_next = vf_mem[line_inc];
  wire [1:0] fw_fv = vf_mem[line_reg];
  wire marker = rx_eav && (rx_fv == FV_MARK) && (prev_fv_reg != FV_MARK);
  // Flywheel check against each received EAV
  wire mismatch = rx_eav && (!fw_eol || rx_fv != fw_fv_next);
  wire mis2 = mismatch && err_valid_reg && (err_pos_reg == pix_reg);
  wire in_active = synced && (pix_reg > sav_reg) && (pix_reg < total_pix - ACT_ADJ);
  wire auto_sw = fw_eol && is_switch(line_reg, std_format, ilace_reg);
  wire force_load = !hold_s || resync_reg || !synced || mis2;
  wire reload_eav = rx_eav && force_load;
  wire reload_sav = rx_sav && force_load && synced;
  wire line_step = synced ? fw_eol : rx_eav;
  wire fw_h = !in_active;
  wire [2:0] hvf_sel = hold_s ? {fw_h, fw_fv[0], fw_fv[1]} : rx_hvf_reg;
  wire [2:0] std_now = std_code(total_lines);
  wire is_1125i = (std_now == STD_1125) && ilace_reg;
  wire seg_now = is_1125i && (pid_segmented || total_pix == PIX_1125_24);

  // Set of a resync request wins over its clear by a TRS word
  assign resync_next = enable && ((resync_reg && !trs) || lock_rise || rst_rise ||
                       (hold_rise && in_active) || auto_sw);
  assign err_valid_next = rx_eav ? (synced && hold_s && mismatch && !mis2) : err_valid_reg;

  always_comb begin
    if (!enable) begin
      pix_next = '0;
    end else if (reload_eav) begin
      pix_next = '0;
    end else if (reload_sav) begin
      pix_next = sav_reg + PIX_ONE;
    end else if (fw_eol) begin
      pix_next = '0;
    end else begin
      pix_next = pix_reg + PIX_ONE;
    end
  end

  always_comb begin
    if (!enable) begin
      line_next = '0;
    end else if (marker && force_load) begin
      line_next = LINE_ONE;
    end else if (line_step) begin
      line_next = line_inc;
    end else begin
      line_next = line_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    if (!enable) begin
      state_next = ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: state_next = ST_LEARN;
        ST_LEARN: state_next = (marker && armed_reg) ? ST_SYNC : ST_LEARN;
        ST_SYNC: state_next = ST_SYNC;
        default: state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      w1_reg <= '0;
      w2_reg <= '0;
      w3_reg <= '0;
      hold_d_reg <= 1'b0;
      rstpin_d_reg <= 1'b0;
      locked_d_reg <= 1'b0;
    end else begin
      w1_reg <= din;
      w2_reg <= w1_reg;
      w3_reg <= w2_reg;
      hold_d_reg <= hold_s;
      rstpin_d_reg <= rstpin_s;
      locked_d_reg <= locked;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      pix_reg <= '0;
      line_reg <= '0;
      resync_reg <= 1'b0;
      err_valid_reg <= 1'b0;
      err_pos_reg <= '0;
      prev_fv_reg <= '0;
      rx_hvf_reg <= 3'h7;
    end else begin
      state_reg <= state_next;
      pix_reg <= pix_next;
      line_reg <= line_next;
      resync_reg <= resync_next;
      err_valid_reg <= enable && err_valid_next;
      if (rx_eav) begin
        err_pos_reg <= pix_reg;
        prev_fv_reg <= rx_fv;
      end
      if (trs) begin
        rx_hvf_reg <= {din[BIT_H], din[BIT_V], din[BIT_F]};
      end
    end
  end

  // Raster learning over one complete frame
  always_ff @(posedge clk) begin
    if (rst) begin
      armed_reg <= 1'b0;
      ilace_reg <= 1'b0;
      act_cnt_reg <= '0;
      sav_reg <= '0;
      total_pix <= '0;
      active_pix <= '0;
      total_lines <= '0;
      active_lines <= '0;
    end else if (learning) begin
      if (marker) begin
        armed_reg <= 1'b1;
        act_cnt_reg <= '0;
      end else if (rx_eav && armed_reg && !din[BIT_V]) begin
        act_cnt_reg <= act_cnt_reg + LINE_ONE;
      end
      if (marker && armed_reg) begin
        total_lines <= line_reg;
        active_lines <= act_cnt_reg;
      end
      if (rx_sav) begin
        sav_reg <= pix_reg;
      end
      if (rx_eav && armed_reg) begin
        total_pix <= pix_reg + PIX_ONE;
        active_pix <= pix_reg - sav_reg - ACT_ADJ;
        ilace_reg <= ilace_reg | din[BIT_F];
      end
    end else if (!synced) begin
      armed_reg <= 1'b0;
      ilace_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (learning && rx_eav) begin
      vf_mem[line_next] <= rx_fv;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timing_valid <= 1'b0;
      h_out <= 1'b1;
      v_out <= 1'b1;
      f_out <= 1'b0;
      reload_pulse <= 1'b0;
      std_format <= STD_NONE;
      std_interlaced <= 1'b0;
      std_segmented <= 1'b0;
    end else begin
      timing_valid <= (state_next == ST_SYNC);
      h_out <= hvf_sel[2];
      v_out <= hvf_sel[1];
      f_out <= hvf_sel[0];
      reload_pulse <= enable && reload_eav;
      std_format <= synced ? std_now : STD_NONE;
      std_interlaced <= synced && ilace_reg && !seg_now;
      std_segmented <= synced && seg_now;
    end
  end

  a_idle_when_off: assert property (@(posedge clk) disable iff (rst)
    !enable |=> state_reg == ST_IDLE && pix_reg == '0 && line_reg == '0)
    else $error("flywheel not idle while disabled");
  a_reload_hold_low: assert property (@(posedge clk) disable iff (rst)
    enable && !hold_s && rx_eav |=> pix_reg == '0 && reload_pulse)
    else $error("EAV did not reload with hold select low");
  a_lock_rise_resync: assert property (@(posedge clk) disable iff (rst)
    enable && (lock_rise || rst_rise) |=> resync_reg)
    else $error("rising lock or reset missed resync");
  a_hold_rise_resync: assert property (@(posedge clk) disable iff (rst)
    enable && hold_rise && in_active |=> resync_reg ##0 (resync_reg || trs))
    else $error("hold select rise in active line missed resync");
  a_switch_line: assert property (@(posedge clk) disable iff (rst)
    enable && auto_sw |=> resync_reg)
    else $error("switch line did not request resync");
  a_sync_after_frame: assert property (@(posedge clk) disable iff (rst)
    $rose(state_reg == ST_SYNC) |-> $past(marker) && $past(armed_reg))
    else $error("sync declared without a full frame");
  a_valid_tracks_sync: assert property (@(posedge clk) disable iff (rst)
    timing_valid == (state_reg == ST_SYNC))
    else $error("timing valid disagrees with sync state");
  a_hold_filter: assert property (@(posedge clk) disable iff (rst)
    enable && synced && hold_s && !resync_reg && rx_eav && !mis2 && !fw_eol
    && pix_reg != '1 |=> pix_reg != '0)
    else $error("single mismatched line reloaded the flywheel");
  a_count_run: assert property (@(posedge clk) disable iff (rst)
    enable && synced && !trs && !fw_eol |=> pix_reg == $past(pix_reg) + PIX_ONE)
    else $error("pixel counter did not advance");
endmodule : vfsr_flywheel

//--- verif/vfsr_src.sv
// Upstream word source: aligned stream of a small 525-line progressive raster
`timescale 1ns/1ps
module vfsr_src (
  input wire logic clk, // Pixel clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [3:0] extra, // Words added to the next line
  output logic [vfsr_pkg::WORD_W-1:0] din, // Aligned word
  output logic [11:0] src_pix, // Word position in line
  output logic [10:0] src_line // Line number, 1 is first blanking line
);
  import vfsr_pkg::*;
  localparam int LEN = 24;
  logic [3:0] ext_reg;
  logic [9:0] xyz;
  logic line_end;
  // EAV at words 0-3, SAV at words 6-9, active from word 10
  assign line_end = (src_pix == (12'(LEN - 1) + 12'(ext_reg)));
  assign xyz = {1'b1, 1'b0, src_line <= 11'h013, src_pix < 12'h006, 6'h00};
  always_comb begin
    case (src_pix)
      12'h000, 12'h006: din = TRS_ONES;
      12'h001, 12'h002, 12'h007, 12'h008: din = TRS_ZERO;
      12'h003, 12'h009: din = xyz;
      default: din = (src_pix < 12'h006) ? 10'h040 : 10'h200;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      src_pix <= 12'h000;
      src_line <= 11'h1f4;
      ext_reg <= 4'h0;
    end else if (line_end) begin
      src_pix <= 12'h000;
      ext_reg <= extra;
      src_line <= (src_line == LINES_525) ? LINE_ONE : src_line + LINE_ONE;
    end else begin
      src_pix <= src_pix + 12'h001;
    end
  end
endmodule : vfsr_src

//--- verif/testbench.sv
// Self-checking testbench for the video flywheel
`timescale 1ns/1ps
module testbench;
  import vfsr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic smpte_mode = 1'b1;
  logic locked = 1'b1;
  logic reset_n_pin = 1'b1;
  logic hold = 1'b1;
  logic [3:0] extra = 4'h0;
  logic [9:0] din;
  logic [11:0] src_pix, total_pix, active_pix;
  logic [10:0] src_line, total_lines, active_lines, pulse_line;
  logic timing_valid, h_out, v_out, f_out, reload_pulse, std_interlaced, std_segmented;
  logic [2:0] std_format;
  int error_cnt = 0;
  int checked = 0;
  int pulse_cnt = 0;
  int cyc = 0;

  vfsr_src u_vfsr_src (.clk(clk), .rst(rst), .extra(extra), .din(din), .src_pix(src_pix),
    .src_line(src_line));
  vfsr_flywheel u_vfsr_flywheel (.clk(clk), .rst(rst), .din(din), .smpte_mode(smpte_mode),
    .locked(locked), .combined_reset_n_pin(reset_n_pin), .flywheel_hold_select(hold),
    .pid_segmented(1'b0), .timing_valid(timing_valid), .h_out(h_out), .v_out(v_out),
    .f_out(f_out), .reload_pulse(reload_pulse), .total_pix(total_pix),
    .active_pix(active_pix), .total_lines(total_lines), .active_lines(active_lines),
    .std_format(std_format), .std_interlaced(std_interlaced), .std_segmented(std_segmented));

  always #50 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (reload_pulse === 1'b1) begin
      pulse_cnt++;
      pulse_line = src_line;
    end
    if (cyc == 80000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic at_pix(input int px);
    do @(negedge clk); while (src_pix != 12'(px));
  endtask : at_pix

  task automatic go_to(input int ln, input int px);
    do at_pix(px); while (src_line != 11'(ln));
  endtask : go_to

  // Learned raster of the 24-word, 525-line source with 19 blanking lines
  task automatic learn_raster();
    while (timing_valid !== 1'b1) @(negedge clk);
    // Format outputs register one edge after the sync state
    @(negedge clk);
    check("total_pix", 12'h018, total_pix);
    check("active_pix", 12'h00e, active_pix);
    check("total_lines", LINES_525, total_lines);
    check("active_lines", 11'h1fa, active_lines);
    check("std_format", STD_525, std_format);
    check("std_interlaced", 12'h000, std_interlaced);
    check("std_segmented", 12'h000, std_segmented);
  endtask : learn_raster

  task automatic t_learn();
    repeat (200) @(negedge clk);
    check("timing_valid early", 12'h000, timing_valid);
    learn_raster();
  endtask : t_learn

  task automatic t_auto_switch();
    go_to(1, 0);
    pulse_cnt = 0;
    go_to(9, 5);
    check("fw v blank", 12'h001, v_out);
    // Stretch line 10 so the next EAV arrives late
    extra = 4'h3;
    at_pix(5);
    extra = 4'h0;
    go_to(1, 0);
    check("pulses per frame", 12'h001, pulse_cnt[11:0]);
    check("pulse line", 12'h00b, pulse_line);
  endtask : t_auto_switch

  task automatic t_two_line();
    go_to(99, 13);
    check("fw h active", 12'h000, h_out);
    check("fw v active", 12'h000, v_out);
    go_to(100, 5);
    extra = 4'h3;
    at_pix(5);
    extra = 4'h0;
    pulse_cnt = 0;
    go_to(103, 0);
    check("first mismatch", 12'h000, pulse_cnt[11:0]);
    go_to(104, 0);
    check("second mismatch", 12'h001, pulse_cnt[11:0]);
  endtask : t_two_line

  task automatic t_manual();
    go_to(200, 10);
    hold = 1'b0;
    repeat (4) @(negedge clk);
    hold = 1'b1;
    pulse_cnt = 0;
    at_pix(10);
    check("manual resync", 12'h001, pulse_cnt[11:0]);
  endtask : t_manual

  task automatic t_follow();
    go_to(300, 5);
    hold = 1'b0;
    at_pix(0);
    pulse_cnt = 0;
    at_pix(7);
    check("h after eav", 12'h001, h_out);
    at_pix(13);
    check("h after sav", 12'h000, h_out);
    check("v active", 12'h000, v_out);
    check("f field one", 12'h000, f_out);
    repeat (5) at_pix(0);
    check("reload every eav", 12'h005, pulse_cnt[11:0]);
    hold = 1'b1;
  endtask : t_follow

  task automatic t_disable();
    smpte_mode = 1'b0;
    repeat (2) @(negedge clk);
    check("valid out of mode", 12'h000, timing_valid);
    check("format out of mode", STD_NONE, std_format);
    smpte_mode = 1'b1;
    reset_n_pin = 1'b0;
    repeat (8) @(negedge clk);
    check("valid in reset", 12'h000, timing_valid);
    reset_n_pin = 1'b1;
    repeat (8) @(negedge clk);
    locked = 1'b0;
    repeat (2) @(negedge clk);
    check("valid unlocked", 12'h000, timing_valid);
    at_pix(5);
    locked = 1'b1;
    pulse_cnt = 0;
    at_pix(5);
    check("resync on lock", 12'h001, pulse_cnt[11:0]);
    learn_raster();
  endtask : t_disable

  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_learn();
    t_auto_switch();
    t_two_line();
    t_manual();
    t_follow();
    t_disable();
    report_and_stop();
  end
endmodule : testbench
